//--- hw/bank_defines.svh
`ifndef BANK_DEFINES_SVH
`define BANK_DEFINES_SVH
// ==================================================
// command codes on {cs_n, ras_n, cas_n, we_n}
`define CMD_NOP 4'h7
`define CMD_ACT 4'h3
`define CMD_RD 4'h5
`define CMD_WR 4'h4
`define CMD_PRE 4'h2
`define CMD_BST 4'h6
`define CMD_REF 4'h1
`define CMD_LMR 4'h0
// address bit that selects auto precharge / all banks
`define AP_BIT 10
// default interval counts in cycles (50 MHz)
`define TRP_CYC 8'h02
`define TRCD_CYC 8'h02
`define TRC_CYC 8'h04
`define TMRD_CYC 8'h01
`define TWR_CYC 8'h01
`define BURST_CYC 8'h02
`define RDPRE_CYC 8'h02
`define CNT_ONE 8'h01
`define CNT_ZERO 8'h00
`endif

//--- hw/bank_pkg.sv
package bank_pkg;
  // per-bank state
  typedef enum logic [3:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
    BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING, BK_REFRESH, BK_MODE
  } bank_state_t;
  // decoded command
  typedef enum logic [3:0] {
    C_DESEL, C_NOP, C_ACT, C_RD, C_WR, C_PRE, C_BST, C_REF, C_LMR
  } cmd_t;
endpackage

//--- hw/bank_if.sv
`include "bank_defines.svh"
// ==================================================
// carrier between the command tracker and each bank engine
interface bank_if;
  import bank_pkg::*;
  cmd_t cmd;
  logic hit;
  logic ap;
  logic ok;
  bank_state_t state;
  logic [7:0] trp;
  logic [7:0] trcd;
  logic [7:0] trc;
  logic [7:0] tmrd;
  logic [7:0] twr;
  logic [7:0] burst;
  logic [7:0] rdpre;
  modport ctl (output cmd, hit, ap, ok, trp, trcd, trc, tmrd, twr, burst, rdpre, input state);
  modport bank (input cmd, hit, ap, ok, trp, trcd, trc, tmrd, twr, burst, rdpre, output state);
endinterface

//--- hw/bank_engine.sv
`include "bank_defines.svh"
// ==================================================
// one bank: state register and interval down-counter
module bank_engine (
  input wire logic sys_clk,
  input wire logic srst,
  bank_if.bank bi
);
  import bank_pkg::*;
  bank_state_t state_r;
  logic [7:0] cnt_r;
  logic in_pre_r; // access period over, precharge period running
  assign bi.state = state_r;

  // ==================================================
  // state transitions
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= BK_IDLE;
      cnt_r <= `CNT_ZERO;
      in_pre_r <= 1'b0;
    end else if (bi.ok && bi.cmd == C_REF) begin
      state_r <= BK_REFRESH;
      cnt_r <= bi.trc;
    end else if (bi.ok && bi.cmd == C_LMR) begin
      state_r <= BK_MODE;
      cnt_r <= bi.tmrd;
    end else if (bi.ok && bi.hit && bi.cmd == C_PRE &&
                 state_r inside {BK_ACTIVE, BK_READ, BK_WRITE}) begin
      state_r <= BK_PRECHARGING;
      cnt_r <= bi.trp;
    end else if (bi.ok && bi.hit && bi.cmd == C_ACT && state_r == BK_IDLE) begin
      state_r <= BK_ACTIVATING;
      cnt_r <= bi.trcd;
    end else if (bi.ok && bi.hit && ((bi.cmd == C_RD && state_r inside {BK_ACTIVE, BK_READ, BK_WRITE}) ||
                 (bi.cmd == C_WR && state_r inside {BK_ACTIVE, BK_WRITE}))) begin
      if (bi.ap) begin
        state_r <= (bi.cmd == C_RD) ? BK_READ_AP : BK_WRITE_AP;
        cnt_r <= (bi.cmd == C_RD) ? bi.rdpre : 8'(bi.burst + bi.twr);
      end else begin
        state_r <= (bi.cmd == C_RD) ? BK_READ : BK_WRITE;
        cnt_r <= bi.burst;
      end
      in_pre_r <= 1'b0;
    end else if (bi.ok && bi.hit && bi.cmd == C_BST && state_r == BK_READ) begin
      state_r <= BK_ACTIVE;
    end else if (cnt_r > `CNT_ONE) begin
      cnt_r <= 8'(cnt_r - `CNT_ONE);
    end else begin
      // interval expired
      case (state_r)
        BK_PRECHARGING, BK_REFRESH, BK_MODE: state_r <= BK_IDLE;
        BK_ACTIVATING, BK_READ, BK_WRITE: state_r <= BK_ACTIVE;
        BK_READ_AP, BK_WRITE_AP: begin
          if (in_pre_r) begin
            state_r <= BK_IDLE;
            in_pre_r <= 1'b0;
          end else begin
            in_pre_r <= 1'b1;
            cnt_r <= bi.trp;
          end
        end
        default: state_r <= state_r;
      endcase
    end
  end

  // ==================================================
  // checks
  idle_after_pre_a: assert property (@(posedge sys_clk) disable iff (srst)
    (bi.ok && bi.hit && bi.cmd == C_PRE && state_r == BK_ACTIVE && bi.trp == `TRP_CYC)
    |=> (state_r == BK_PRECHARGING)[*2] ##1 state_r == BK_IDLE)
    else $error("precharge did not end in idle");
  activate_opens_a: assert property (@(posedge sys_clk) disable iff (srst)
    (bi.ok && bi.hit && bi.cmd == C_ACT && state_r == BK_IDLE && bi.trcd == `TRCD_CYC)
    |=> state_r == BK_ACTIVATING ##2 state_r == BK_ACTIVE)
    else $error("activate did not reach row active");
  refresh_ends_a: assert property (@(posedge sys_clk) disable iff (srst)
    (bi.ok && bi.cmd == C_REF && bi.trc == `TRC_CYC) |=> ##4 state_r == BK_IDLE)
    else $error("refresh not ended after row cycle");
  mode_ends_a: assert property (@(posedge sys_clk) disable iff (srst)
    (bi.ok && bi.cmd == C_LMR && bi.tmrd == `TMRD_CYC) |=> state_r == BK_MODE ##1 state_r == BK_IDLE)
    else $error("mode access not ended");
  burst_stop_a: assert property (@(posedge sys_clk) disable iff (srst)
    (bi.ok && bi.hit && bi.cmd == C_BST && state_r == BK_READ) |=> state_r == BK_ACTIVE)
    else $error("burst terminate ignored");
  nop_holds_a: assert property (@(posedge sys_clk) disable iff (srst)
    ((bi.cmd == C_NOP || bi.cmd == C_DESEL) && state_r == BK_ACTIVE) |=> state_r == BK_ACTIVE)
    else $error("nop changed an active bank");
  pre_truncates_a: assert property (@(posedge sys_clk) disable iff (srst)
    (bi.ok && bi.hit && bi.cmd == C_PRE && state_r inside {BK_READ, BK_WRITE}) |=> state_r == BK_PRECHARGING)
    else $error("precharge did not truncate burst");
  ap_split_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_r == BK_READ_AP && !in_pre_r && cnt_r == `CNT_ONE &&
     !(bi.ok && (bi.hit || bi.cmd == C_REF || bi.cmd == C_LMR))) |=> in_pre_r)
    else $error("auto precharge period not started");
  cov_ap_c: cover property (@(posedge sys_clk) state_r == BK_WRITE_AP ##[1:20] state_r == BK_IDLE);
  cov_bst_c: cover property (@(posedge sys_clk) state_r == BK_READ ##1 state_r == BK_ACTIVE);
  cov_ref_c: cover property (@(posedge sys_clk) state_r == BK_REFRESH);
endmodule // bank_engine

//--- hw/bank_tracker.sv
// Overview of operation
// - PRECHARGE truncates non-AP burst, starts precharging
// - BURST TERMINATE ends most recent read burst
// - rules apply only with clock enable high
// - idle after tRP, active after tRCD
// - AUTO REFRESH idles banks after tRC
// - LOAD MODE idles banks after tMRD
// - accept legal commands to other banks
// - auto precharge allows other-bank commands
// - auto precharge splits access and precharge
// - DESELECT and NOP continue previous operation
// - decode ACTIVE, open row
// - decode READ and WRITE, optional AP
// - A10 chooses one or all banks
`include "bank_defines.svh"
module bank_tracker #(
  parameter int NUM_BANKS = 4,
  parameter logic [7:0] TRP = `TRP_CYC,
  parameter logic [7:0] TRCD = `TRCD_CYC,
  parameter logic [7:0] TRC = `TRC_CYC,
  parameter logic [7:0] TMRD = `TMRD_CYC,
  parameter logic [7:0] TWR = `TWR_CYC,
  parameter logic [7:0] BURST = `BURST_CYC,
  parameter logic [7:0] RDPRE = `RDPRE_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_addr,
  input wire logic [12:0] addr,
  output logic [NUM_BANKS*4-1:0] bank_state,
  output logic all_idle,
  output logic cmd_illegal
);
  import bank_pkg::*;

  initial begin
    if (NUM_BANKS != 4) $error("four banks only");
    if (TRP == 8'h00 || TRCD == 8'h00 || TRC == 8'h00 || TMRD == 8'h00 || BURST == 8'h00)
      $error("interval counts must be nonzero");
  end

  // ==================================================
  // command decode
  function automatic cmd_t decode(input logic cs, input logic ra, input logic ca, input logic we);
    if (cs) return C_DESEL;
    case ({cs, ra, ca, we})
      `CMD_NOP: return C_NOP;
      `CMD_ACT: return C_ACT;
      `CMD_RD: return C_RD;
      `CMD_WR: return C_WR;
      `CMD_PRE: return C_PRE;
      `CMD_BST: return C_BST;
      `CMD_REF: return C_REF;
      `CMD_LMR: return C_LMR;
      default: return C_NOP;
    endcase
  endfunction

  cmd_t cmd;
  logic cke_prev_r;
  logic ok;
  logic [1:0] last_rd_bank_r;
  logic [NUM_BANKS-1:0] busy;
  logic [NUM_BANKS-1:0] idle_v;
  bank_state_t st [NUM_BANKS];
  logic illegal_nxt;

  assign cmd = decode(cs_n, ras_n, cas_n, we_n);

  // previous clock enable level
  always_ff @(posedge sys_clk) begin
    if (srst) cke_prev_r <= 1'b0;
    else cke_prev_r <= cke;
  end
  assign ok = cke_prev_r && cke;

  // bank of the most recent read, for burst terminate
  always_ff @(posedge sys_clk) begin
    if (srst) last_rd_bank_r <= 2'h0;
    else if (ok && cmd == C_RD) last_rd_bank_r <= bank_addr;
  end

  // ==================================================
  // bank engines
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      bank_if bi ();
      assign bi.cmd = cmd;
      assign bi.ok = ok;
      assign bi.ap = addr[`AP_BIT];
      // all-bank precharge ignores bank address; each bank judges itself
      assign bi.hit = (cmd == C_BST) ? (last_rd_bank_r == 2'(g)) :
                      (cmd == C_PRE && addr[`AP_BIT]) ? 1'b1 : (bank_addr == 2'(g));
      assign bi.trp = TRP;
      assign bi.trcd = TRCD;
      assign bi.trc = TRC;
      assign bi.tmrd = TMRD;
      assign bi.twr = TWR;
      assign bi.burst = BURST;
      assign bi.rdpre = RDPRE;
      assign st[g] = bi.state;
      assign idle_v[g] = (bi.state == BK_IDLE);
      assign busy[g] = bi.state inside {BK_ACTIVATING, BK_PRECHARGING, BK_READ_AP, BK_WRITE_AP};
      bank_engine u_bank (
        .sys_clk(sys_clk),
        .srst(srst),
        .bi(bi)
      );
    end
  endgenerate

  // registered state out, one process drives the whole vector
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bank_state <= {(NUM_BANKS*4){1'b0}};
    end else begin
      for (int k = 0; k < NUM_BANKS; k++) begin
        bank_state[k*4 +: 4] <= 4'(st[k]);
      end
    end
  end

  // ==================================================
  // flag commands the controller should not have sent
  always_comb begin
    illegal_nxt = 1'b0;
    if (ok) begin
      case (cmd)
        C_REF, C_LMR: illegal_nxt = (idle_v != {NUM_BANKS{1'b1}});
        C_ACT: illegal_nxt = (st[bank_addr] != BK_IDLE);
        C_RD: illegal_nxt = !(st[bank_addr] inside {BK_ACTIVE, BK_READ, BK_WRITE});
        C_WR: illegal_nxt = !(st[bank_addr] inside {BK_ACTIVE, BK_WRITE});
        C_PRE: illegal_nxt = addr[`AP_BIT] ? (busy != {NUM_BANKS{1'b0}}) : busy[bank_addr];
        C_BST: illegal_nxt = (st[last_rd_bank_r] != BK_READ);
        default: illegal_nxt = 1'b0;
      endcase
      if (st[0] inside {BK_REFRESH, BK_MODE} && !(cmd inside {C_NOP, C_DESEL}))
        illegal_nxt = 1'b1;
    end
  end

  // status outputs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmd_illegal <= 1'b0;
      all_idle <= 1'b1;
    end else begin
      cmd_illegal <= illegal_nxt;
      all_idle <= (idle_v == {NUM_BANKS{1'b1}});
    end
  end

  // ==================================================
  // checks
  cke_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!ok && cmd == C_ACT && st[bank_addr] == BK_IDLE) |=> st[$past(bank_addr)] != BK_ACTIVATING)
    else $error("command acted with clock enable low");
  other_bank_a: assert property (@(posedge sys_clk) disable iff (srst)
    (ok && cmd == C_ACT && bank_addr == 2'h1 && st[1] == BK_IDLE && st[0] == BK_READ_AP)
    |=> st[1] == BK_ACTIVATING && !cmd_illegal)
    else $error("other bank activate refused");
  cov_ill_c: cover property (@(posedge sys_clk) cmd_illegal);
  cov_all_c: cover property (@(posedge sys_clk) ok && cmd == C_PRE && addr[`AP_BIT]);
endmodule // bank_tracker

//--- dv/ctrl_model.sv
`include "bank_defines.svh"
// ==================================================
// controller model: one command per call, bus released after
module ctrl_model (
  input wire logic sys_clk,
  input wire logic all_idle,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bank_addr,
  output logic [12:0] addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet bus at start, clock enable held high
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = `CMD_NOP;
    bank_addr = 2'h0;
    addr = 13'h0000;
  end
  task automatic set_cke(input logic v);
    @(negedge sys_clk);
    cke = v;
  endtask
  // drive for one edge, then deselect with flipped lines
  task automatic issue(input logic [3:0] code, input logic [1:0] ba, input logic a10);
    @(negedge sys_clk);
    while ((code == `CMD_REF || code == `CMD_LMR) && all_idle !== 1'b1) @(negedge sys_clk);
    {cs_n, ras_n, cas_n, we_n} = code;
    bank_addr = ba;
    addr = (13'($urandom) & ~13'h0400) | (13'(a10) << 10);
    @(negedge sys_clk);
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = ~{ras_n, cas_n, we_n};
    bank_addr = ~bank_addr;
    addr = ~addr;
  endtask
endmodule // ctrl_model

//--- dv/tb.sv
`include "bank_defines.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end
// ==================================================
// bench: controller model drives the tracker, bank fields checked
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bank_pkg::*;
  logic sys_clk, srst, cke, cs_n, ras_n, cas_n, we_n, all_idle, cmd_illegal;
  logic [1:0] bank_addr;
  logic [12:0] addr;
  logic [15:0] bank_state;
  int fails, samples_checked;
  bank_tracker #(.BURST(8'h08), .RDPRE(8'h08)) u_dut (.sys_clk(sys_clk), .srst(srst), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr),
    .bank_state(bank_state), .all_idle(all_idle), .cmd_illegal(cmd_illegal));
  ctrl_model u_ctrl (.sys_clk(sys_clk), .all_idle(all_idle), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr));
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // state a bank settles in once an ACT, a read or an AP write has run its course
  function automatic logic [3:0] settle(input logic [3:0] code, input logic a10);
    return (code == `CMD_ACT || (code == `CMD_RD && !a10)) ? BK_ACTIVE : BK_IDLE;
  endfunction
  // wait a bounded number of cycles for a bank field to reach a value
  task automatic wait_st(input string nm, input int b, input logic [3:0] e, input int lim);
    logic [3:0] g;
    g = bank_state[b*4 +: 4];
    for (int i = 0; i < lim && g !== e; i++) begin
      @(negedge sys_clk);
      g = bank_state[b*4 +: 4];
    end
    `CHK(nm, e, g)
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog against a hung wait
  initial begin
    #100us;
    fails++;
    stop_test();
  end
  // main sequence
  initial begin
    logic [1:0] b, o;
    fails = 0;
    samples_checked = 0;
    void'($urandom(32'h6EE3DA8C));
    srst = 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) srst = 1'b0;
    `CHK("all_idle", 1'b1, all_idle)
    `CHK("states", 16'h0000, bank_state)
    `CHK("illegal", 1'b0, cmd_illegal)
    repeat (2) @(negedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      b = 2'(i);
      u_ctrl.issue(`CMD_ACT, b, 1'b0);
      wait_st("activating", i, BK_ACTIVATING, 3);
      wait_st("active", i, settle(`CMD_ACT, 1'b0), 6);
      u_ctrl.issue(`CMD_RD, b, 1'b0);
      wait_st("read", i, BK_READ, 3);
      wait_st("read end", i, settle(`CMD_RD, 1'b0), 12);
      u_ctrl.issue(`CMD_WR, b, 1'b1); // write only once the read has ended
      wait_st("write ap", i, BK_WRITE_AP, 3);
      // access, write recovery and precharge period: 8 + 1 + 2 cycles in one state
      repeat (10) @(negedge sys_clk);
      `CHK("ap prechg", BK_WRITE_AP, bank_state[i*4 +: 4])
      wait_st("ap idle", i, settle(`CMD_WR, 1'b1), 6); // next command waits for idle
    end
    $display("test bank walk done");
    b = 2'($urandom);
    o = b + 2'h1;
    u_ctrl.issue(`CMD_ACT, b, 1'b0);
    u_ctrl.issue(`CMD_ACT, o, 1'b0);
    wait_st("other act", o, BK_ACTIVE, 6);
    u_ctrl.issue(`CMD_RD, b, 1'b0);
    wait_st("read b", b, BK_READ, 3);
    u_ctrl.issue(`CMD_BST, b, 1'b0);
    wait_st("terminated", b, BK_ACTIVE, 4);
    u_ctrl.issue(`CMD_RD, b, 1'b0);
    wait_st("read b2", b, BK_READ, 3);
    u_ctrl.issue(`CMD_PRE, b, 1'b0);
    wait_st("truncate", b, BK_PRECHARGING, 3);
    wait_st("pre idle", b, BK_IDLE, 4);
    `CHK("other kept", BK_ACTIVE, bank_state[o*4 +: 4])
    $display("test terminate done");
    u_ctrl.set_cke(1'b0);
    u_ctrl.issue(`CMD_ACT, b, 1'b0);
    repeat (4) @(negedge sys_clk);
    `CHK("cke low", BK_IDLE, bank_state[b*4 +: 4])
    u_ctrl.set_cke(1'b1);
    repeat (2) @(negedge sys_clk);
    $display("test clock enable done");
    u_ctrl.issue(`CMD_ACT, b, 1'b0);
    wait_st("act b", b, BK_ACTIVE, 6);
    u_ctrl.issue(`CMD_RD, b, 1'b1);
    u_ctrl.issue(`CMD_PRE, o, 1'b0);
    wait_st("concurrent", o, BK_PRECHARGING, 3);
    wait_st("rd ap idle", b, BK_IDLE, 14);
    u_ctrl.issue(`CMD_ACT, b, 1'b0);
    u_ctrl.issue(`CMD_ACT, o, 1'b0);
    wait_st("b act", b, BK_ACTIVE, 6);
    wait_st("o act", o, BK_ACTIVE, 6);
    u_ctrl.issue(`CMD_PRE, 2'($urandom), 1'b1);
    wait_st("all b", b, BK_PRECHARGING, 3);
    wait_st("all o", o, BK_IDLE, 6);
    $display("test precharge done");
    u_ctrl.issue(`CMD_REF, 2'h0, 1'b0);
    wait_st("refresh", b, BK_REFRESH, 3);
    wait_st("ref idle", b, BK_IDLE, 8);
    u_ctrl.issue(`CMD_LMR, 2'h0, 1'b0);
    wait_st("mode", o, BK_MODE, 3);
    wait_st("mode idle", o, BK_IDLE, 4);
    $display("test refresh mode done");
    u_ctrl.issue(`CMD_RD, b, 1'b0);
    for (int i = 0; i < 3 && cmd_illegal !== 1'b1; i++) @(negedge sys_clk);
    `CHK("refused", 1'b1, cmd_illegal)
    `CHK("ignored", BK_IDLE, bank_state[b*4 +: 4])
    $display("test refusal done");
    repeat (6) begin
      b = 2'($urandom);
      u_ctrl.issue(`CMD_ACT, b, 1'b0);
      wait_st("r act", b, BK_ACTIVE, 6);
      u_ctrl.issue(`CMD_WR, b, 1'b0);
      wait_st("r wr", b, BK_WRITE, 3);
      u_ctrl.issue(`CMD_PRE, b, 1'b0); // no read cuts a write, so no mask is owed
      wait_st("r pre", b, BK_PRECHARGING, 3);
      wait_st("r idle", b, BK_IDLE, 4);
    end
    $display("test random done");
    stop_test();
  end
endmodule // tb
